// *** hw/gsr_ahb_slave.sv ***
// AHB-Lite slave front end with zero wait states for the gauge result bank.
`timescale 1ns/1ps
`include "gsr_defs.svh"
module gsr_ahb_slave
  import gsr_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rstn,
  // AHB-Lite.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Register side.
  output logic      [7:0]  rdIdx,
  input  wire logic [15:0] rdData,
  input  wire logic        rdHit,
  output logic             wrStrobe,
  output logic      [7:0]  wrIdx,
  output logic      [15:0] wrData
);
  logic addrOk;
  logic phaseRd;
  logic phaseWr;
  logic wrPend_r;

  assign addrOk   = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0) && (hsize == 3'h2);
  assign phaseRd  = hsel && htrans[1] && hready && !hwrite;
  assign phaseWr  = hsel && htrans[1] && hready && hwrite && addrOk;
  assign rdIdx    = haddr[9:2];
  assign wrStrobe = wrPend_r;
  assign wrData   = hwdata[15:0];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // The whole word is captured in one edge so both bytes belong to the same refresh.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      hrdata <= 32'h00000000;
    else if (phaseRd)
      hrdata <= (addrOk && rdHit) ? {16'h0000, rdData} : 32'h00000000;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPend_r <= 1'b0;
      wrIdx    <= 8'h00;
    end
    else
    begin
      wrPend_r <= phaseWr;
      if (phaseWr)
        wrIdx <= haddr[9:2];
    end
  end
endmodule : gsr_ahb_slave

// *** hw/gsr_defs.svh ***
// Register indices, field positions, reset values and timing counts of the gauge result bank.
`ifndef GSR_DEFS_SVH
`define GSR_DEFS_SVH
`define GSR_IDX_FLAGS       8'h0A
`define GSR_IDX_UNCOMP_REM  8'h0C
`define GSR_IDX_UNCOMP_FULL 8'h0E
`define GSR_IDX_COMP_REM    8'h10
`define GSR_IDX_COMP_FULL   8'h12
`define GSR_IDX_MEAN_CUR    8'h14
`define GSR_IDX_TTE         8'h16
`define GSR_IDX_TTF         8'h18
`define GSR_IDX_IDLE_CUR    8'h1A
`define GSR_IDX_IDLE_TTE    8'h1C
`define GSR_IDX_PEAK_CUR    8'h1E
`define GSR_IDX_PEAK_TTE    8'h20
`define GSR_IDX_ENERGY      8'h22
`define GSR_IDX_POWER       8'h24
`define GSR_IDX_CP_TTE      8'h26
`define GSR_IDX_CTRL        8'h40
`define GSR_BIT_OTC         15
`define GSR_BIT_OTD         14
`define GSR_BIT_INHIBIT     11
`define GSR_BIT_SUSPEND     10
`define GSR_BIT_FULL        9
`define GSR_BIT_FAST        8
`define GSR_BIT_ONE         6
`define GSR_BIT_OCV         5
`define GSR_BIT_AWAITING_PACK_IDENTIFY     4
`define GSR_BIT_PACK        3
`define GSR_BIT_CHARGE_LEVEL_THRESHOLD_ONE        2
`define GSR_BIT_SYSTEM_SHUTDOWN_FLAG     1
`define GSR_BIT_DISCHARGE   0
`define GSR_CTRL_MATCH_BIT  0
`define GSR_CTRL_RESET      1'h0
`define GSR_FLAGS_RESET     16'h0040
`define GSR_WORD_RESET      16'h0000
`define GSR_NO_ESTIMATE     16'hFFFF
`define GSR_MAX_ESTIMATE    32'h0000FFFE
`define GSR_MIN_PER_HOUR    32'h0000003C
`define GSR_HALF_SOC        8'h32
`define GSR_IDLE_SHIFT      4
`define GSR_REFRESH_MS      1000
`define GSR_CLK_PERIOD_NS   10
`define GSR_REFRESH_CYCLES  (`GSR_REFRESH_MS * 1000000 / `GSR_CLK_PERIOD_NS)
`endif

// *** hw/gsr_idle_filter.sv ***
// Adaptive standby current estimate with first and last qualifying samples left out.
`timescale 1ns/1ps
`include "gsr_defs.svh"
module gsr_idle_filter
  import gsr_pkg::*;
(
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          rstn,
  // Sampling.
  input  wire logic          tick,
  input  wire gsr_sword_type measCurrent,
  input  wire gsr_sword_type initIdle,
  input  wire gsr_word_type  deadband,
  // Result.
  output gsr_sword_type      idleCurrent
);
  logic          primed_r;
  logic          qualify;
  logic          runActive_r;
  logic          leadQual_r;
  gsr_sword_type pending_r;

  assign qualify = (gsr_abs(measCurrent) > deadband) &&
                   ({1'b0, gsr_abs(measCurrent)} <= {gsr_abs(initIdle), 1'b0});

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      primed_r    <= 1'b0;
      runActive_r <= 1'b0;
      leadQual_r  <= 1'b0;
      pending_r   <= 16'sh0000;
      idleCurrent <= 16'sh0000;
    end
    else if (!primed_r)
    begin
      primed_r    <= 1'b1;
      idleCurrent <= initIdle;
    end
    else if (tick)
    begin
      runActive_r <= qualify;
      leadQual_r  <= runActive_r;
      pending_r   <= measCurrent;
      // A sample is folded in only when both its neighbours qualify, so a run's first and last are skipped.
      if (qualify && runActive_r && leadQual_r)
        idleCurrent <= idleCurrent - (idleCurrent >>> `GSR_IDLE_SHIFT)
                       + (pending_r >>> `GSR_IDLE_SHIFT);
    end
  end

  AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    (primed_r && !tick) |=> $stable(idleCurrent))
    else $error("Standby current changed outside a refresh tick.");
endmodule : gsr_idle_filter

// *** hw/gsr_pkg.sv ***
// Types and shared arithmetic of the gauge result bank.
package gsr_pkg;
  typedef logic [15:0]        gsr_word_type;
  typedef logic signed [15:0] gsr_sword_type;

  // Magnitude of a signed current or power, full range kept.
  function automatic gsr_word_type gsr_abs(input gsr_sword_type v);
    gsr_word_type r;
    r = v[15] ? (~v + 16'h0001) : v;
    return r;
  endfunction : gsr_abs
endpackage : gsr_pkg

// *** hw/gsr_result_regs.sv ***
// Status flags and result word bank of the fuel gauge, read over AHB-Lite.
//
// Notes on behaviour
// - Status high byte holds over-temperature, inhibit, suspend, full and fast-charge flags.
// - Status low byte: bit7 zero, bit6 one, then rest-voltage, identify, pack, SOC, shutdown, discharge.
// - Over-temperature flags follow the condition during charge or discharge; all flags active high.
// - Charge inhibit set while temperature is outside the inhibit range.
// - Suspend alert set while temperature is outside the suspend range.
// - Full flag on termination; with matching option cleared the set threshold is minus one percent.
// - Uncompensated remaining and full capacities reported in mAh, refreshed regularly.
// - Compensated remaining and full capacities reported unsigned in mAh.
// - Average current is signed mA and refreshed once a second.
// - Time to empty in minutes, all ones when not discharging.
// - Time to full in minutes, all ones when not charging.
// - Standby current starts at initial value, updates only for qualifying current.
// - First and last qualifying samples are not averaged in.
// - New standby value is fifteen sixteenths old plus one sixteenth new.
// - Standby time to empty from uncompensated remaining capacity, all ones unless discharging.
// - Peak load current starts at initial value and follows larger measured currents.
// - Full charge after discharge below half halves peak toward the initial value.
// - Peak-load time to empty in minutes, all ones unless discharging.
// - Remaining energy reported unsigned in mWh.
// - Average power signed in mW, zero unless discharging.
// - Constant-power time to empty refreshed each second, all ones at zero power.
`timescale 1ns/1ps
`include "gsr_defs.svh"
module gsr_result_regs
  import gsr_pkg::*;
#(
  parameter int TICK_CYCLES = `GSR_REFRESH_CYCLES
)
(
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          rstn,
  // AHB-Lite.
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic          hready,
  input  wire logic [31:0]   hwdata,
  output logic      [31:0]   hrdata,
  output logic               hreadyout,
  output logic               hresp,
  // Temperature and configured limits.
  input  wire gsr_word_type  temperature,
  input  wire gsr_word_type  inhibitTempLow,
  input  wire gsr_word_type  inhibitTempHigh,
  input  wire gsr_word_type  suspendTempLow,
  input  wire gsr_word_type  suspendTempHigh,
  input  wire logic          overTempDetected,
  // Battery state from the estimator.
  input  wire logic          charging,
  input  wire logic          discharging_flag,
  input  wire logic          termination_met,
  input  wire logic [7:0]    stateOfCharge,
  input  wire logic [7:0]    full_flag_set_threshold,
  input  wire logic          fast_charge_allowed,
  input  wire logic          rest_voltage_good_flag,
  input  wire logic          awaiting_pack_identify,
  input  wire logic          pack_present_flag,
  input  wire logic          charge_level_threshold_one,
  input  wire logic          system_shutdown_flag,
  // Result values from the estimator.
  input  wire gsr_word_type  uncompRemaining,
  input  wire gsr_word_type  uncompFull,
  input  wire gsr_word_type  compRemaining,
  input  wire gsr_word_type  compFull,
  input  wire gsr_sword_type avgCurrentIn,
  input  wire gsr_sword_type measCurrent,
  input  wire gsr_word_type  fullTimeIn,
  input  wire gsr_word_type  energyIn,
  input  wire gsr_sword_type avgPowerIn,
  // Configured adaptive seeds.
  input  wire gsr_sword_type initIdleCurrent,
  input  wire gsr_word_type  idleDeadband,
  input  wire gsr_sword_type initPeakLoad,
  // Refresh marker.
  output logic               refreshTick
);
  logic [31:0]   tickCnt_r;
  logic          primed_r;
  logic          capacity_match_option_r;
  logic          belowHalf_r;
  logic          fullPrev_r;
  gsr_word_type  flags_r;
  gsr_word_type  flags_nxt;
  gsr_word_type  uncompRem_r;
  gsr_word_type  uncompFull_r;
  gsr_word_type  compRem_r;
  gsr_word_type  compFull_r;
  gsr_sword_type meanCur_r;
  gsr_word_type  tte_r;
  gsr_word_type  ttf_r;
  gsr_word_type  idleTte_r;
  gsr_sword_type peak_r;
  gsr_word_type  peakTte_r;
  gsr_word_type  energy_r;
  gsr_sword_type power_r;
  gsr_word_type  cpTte_r;
  gsr_sword_type idleCurrent;
  gsr_sword_type powerNow;
  logic [7:0]    rdIdx;
  logic [15:0]   rdData;
  logic          rdHit;
  logic          wrStrobe;
  logic [7:0]    wrIdx;
  logic [15:0]   wrData;
  logic          tempInhibit;
  logic          tempSuspend;
  logic          fullNow;

  // Minutes of run time for a charge at a rate, saturated below the sentinel.
  function automatic gsr_word_type runMinutes(input gsr_word_type amount, input gsr_word_type rate);
    logic [31:0] q;
    q = 32'h00000000;
    if (rate == 16'h0000)
      return `GSR_NO_ESTIMATE;
    q = ({16'h0000, amount} * `GSR_MIN_PER_HOUR) / {16'h0000, rate};
    if (q > `GSR_MAX_ESTIMATE)
      q = `GSR_MAX_ESTIMATE;
    return q[15:0];
  endfunction : runMinutes

  gsr_ahb_slave u_slave (
    .clk       (clk),
    .rstn      (rstn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .rdIdx     (rdIdx),
    .rdData    (rdData),
    .rdHit     (rdHit),
    .wrStrobe  (wrStrobe),
    .wrIdx     (wrIdx),
    .wrData    (wrData)
  );

  gsr_idle_filter u_idle (
    .clk         (clk),
    .rstn        (rstn),
    .tick        (refreshTick),
    .measCurrent (measCurrent),
    .initIdle    (initIdleCurrent),
    .deadband    (idleDeadband),
    .idleCurrent (idleCurrent)
  );

  // One-second refresh divider.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tickCnt_r   <= 32'h00000000;
      refreshTick <= 1'b0;
    end
    else if (tickCnt_r == 32'(TICK_CYCLES - 1))
    begin
      tickCnt_r   <= 32'h00000000;
      refreshTick <= 1'b1;
    end
    else
    begin
      tickCnt_r   <= tickCnt_r + 32'h00000001;
      refreshTick <= 1'b0;
    end
  end

  // Software control word.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      capacity_match_option_r <= `GSR_CTRL_RESET;
    else if (wrStrobe && (wrIdx == `GSR_IDX_CTRL))
      capacity_match_option_r <= wrData[`GSR_CTRL_MATCH_BIT];
  end

  assign tempInhibit = (temperature < inhibitTempLow) || (temperature > inhibitTempHigh);
  assign tempSuspend = (temperature < suspendTempLow) || (temperature > suspendTempHigh);
  // With matching cleared the set threshold sits at minus one percent, so only termination sets it.
  assign fullNow = termination_met ||
                   (capacity_match_option_r && (stateOfCharge >= full_flag_set_threshold));

  always_comb
  begin
    flags_nxt                       = `GSR_FLAGS_RESET;
    flags_nxt[`GSR_BIT_OTC]         = overTempDetected && charging;
    flags_nxt[`GSR_BIT_OTD]         = overTempDetected && discharging_flag;
    flags_nxt[`GSR_BIT_INHIBIT]     = tempInhibit;
    flags_nxt[`GSR_BIT_SUSPEND]     = tempSuspend;
    flags_nxt[`GSR_BIT_FULL]        = fullNow;
    flags_nxt[`GSR_BIT_FAST]        = fast_charge_allowed;
    flags_nxt[`GSR_BIT_OCV]         = rest_voltage_good_flag;
    flags_nxt[`GSR_BIT_AWAITING_PACK_IDENTIFY]     = awaiting_pack_identify;
    flags_nxt[`GSR_BIT_PACK]        = pack_present_flag;
    flags_nxt[`GSR_BIT_CHARGE_LEVEL_THRESHOLD_ONE]        = charge_level_threshold_one;
    flags_nxt[`GSR_BIT_SYSTEM_SHUTDOWN_FLAG]     = system_shutdown_flag;
    flags_nxt[`GSR_BIT_DISCHARGE]   = discharging_flag;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      flags_r <= `GSR_FLAGS_RESET;
    else
      flags_r <= flags_nxt;
  end

  assign powerNow = discharging_flag ? avgPowerIn : 16'sh0000;

  // Result words refreshed on the one-second tick.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      uncompRem_r  <= `GSR_WORD_RESET;
      uncompFull_r <= `GSR_WORD_RESET;
      compRem_r    <= `GSR_WORD_RESET;
      compFull_r   <= `GSR_WORD_RESET;
      meanCur_r    <= 16'sh0000;
      tte_r        <= `GSR_NO_ESTIMATE;
      ttf_r        <= `GSR_NO_ESTIMATE;
      idleTte_r    <= `GSR_NO_ESTIMATE;
      peakTte_r    <= `GSR_NO_ESTIMATE;
      energy_r     <= `GSR_WORD_RESET;
      power_r      <= 16'sh0000;
      cpTte_r      <= `GSR_NO_ESTIMATE;
    end
    else if (refreshTick)
    begin
      uncompRem_r  <= uncompRemaining;
      uncompFull_r <= uncompFull;
      compRem_r    <= compRemaining;
      compFull_r   <= compFull;
      meanCur_r    <= avgCurrentIn;
      tte_r        <= discharging_flag ? runMinutes(compRemaining, gsr_abs(avgCurrentIn))
                                       : `GSR_NO_ESTIMATE;
      ttf_r        <= charging ? fullTimeIn : `GSR_NO_ESTIMATE;
      idleTte_r    <= discharging_flag ? runMinutes(uncompRemaining, gsr_abs(idleCurrent))
                                       : `GSR_NO_ESTIMATE;
      peakTte_r    <= discharging_flag ? runMinutes(compRemaining, gsr_abs(peak_r))
                                       : `GSR_NO_ESTIMATE;
      energy_r     <= energyIn;
      power_r      <= powerNow;
      cpTte_r      <= (powerNow == 16'sh0000) ? `GSR_NO_ESTIMATE
                                              : runMinutes(energyIn, gsr_abs(powerNow));
    end
  end

  // Peak load tracking with relaxation after a deep cycle.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      primed_r    <= 1'b0;
      peak_r      <= 16'sh0000;
      belowHalf_r <= 1'b0;
      fullPrev_r  <= 1'b0;
    end
    else if (!primed_r)
    begin
      primed_r <= 1'b1;
      peak_r   <= initPeakLoad;
    end
    else
    begin
      fullPrev_r <= flags_r[`GSR_BIT_FULL];
      if (flags_r[`GSR_BIT_FULL] && !fullPrev_r && belowHalf_r)
      begin
        belowHalf_r <= 1'b0;
        peak_r      <= 16'((17'(peak_r) + 17'(initPeakLoad)) >>> 1);
      end
      else
      begin
        if (discharging_flag && (stateOfCharge < `GSR_HALF_SOC))
          belowHalf_r <= 1'b1;
        if (refreshTick && (gsr_abs(measCurrent) > gsr_abs(peak_r)))
          peak_r <= measCurrent;
      end
    end
  end

  // Read decode.
  always_comb
  begin
    rdHit  = 1'b1;
    rdData = `GSR_WORD_RESET;
    if (rdIdx == `GSR_IDX_FLAGS)
      rdData = flags_r;
    else if (rdIdx == `GSR_IDX_UNCOMP_REM)
      rdData = uncompRem_r;
    else if (rdIdx == `GSR_IDX_UNCOMP_FULL)
      rdData = uncompFull_r;
    else if (rdIdx == `GSR_IDX_COMP_REM)
      rdData = compRem_r;
    else if (rdIdx == `GSR_IDX_COMP_FULL)
      rdData = compFull_r;
    else if (rdIdx == `GSR_IDX_MEAN_CUR)
      rdData = meanCur_r;
    else if (rdIdx == `GSR_IDX_TTE)
      rdData = tte_r;
    else if (rdIdx == `GSR_IDX_TTF)
      rdData = ttf_r;
    else if (rdIdx == `GSR_IDX_IDLE_CUR)
      rdData = idleCurrent;
    else if (rdIdx == `GSR_IDX_IDLE_TTE)
      rdData = idleTte_r;
    else if (rdIdx == `GSR_IDX_PEAK_CUR)
      rdData = peak_r;
    else if (rdIdx == `GSR_IDX_PEAK_TTE)
      rdData = peakTte_r;
    else if (rdIdx == `GSR_IDX_ENERGY)
      rdData = energy_r;
    else if (rdIdx == `GSR_IDX_POWER)
      rdData = power_r;
    else if (rdIdx == `GSR_IDX_CP_TTE)
      rdData = cpTte_r;
    else if (rdIdx == `GSR_IDX_CTRL)
      rdData = {15'h0000, capacity_match_option_r};
    else
      rdHit = 1'b0;
  end

  AST_FIXED_BITS: assert property (@(posedge clk) disable iff (!rstn)
    (flags_r[13:12] == 2'h0) && (flags_r[7] == 1'b0) && (flags_r[6] == 1'b1))
    else $error("Fixed status bits read wrong.");

  AST_OVERTEMP_CHARGE: assert property (@(posedge clk) disable iff (!rstn)
    (overTempDetected && charging) |=> flags_r[15])
    else $error("Charge over-temperature flag missing.");

  AST_INHIBIT: assert property (@(posedge clk) disable iff (!rstn)
    ((temperature < inhibitTempLow) || (temperature > inhibitTempHigh)) |=> flags_r[11])
    else $error("Charge inhibit flag missing.");

  AST_SUSPEND: assert property (@(posedge clk) disable iff (!rstn)
    tempSuspend |=> flags_r[10] ##1 (flags_r[10] == $past(tempSuspend)))
    else $error("Suspend alert flag does not follow temperature.");

  AST_MEAN_CURRENT: assert property (@(posedge clk) disable iff (!rstn)
    refreshTick |=> (meanCur_r == $past(avgCurrentIn)) ##1 $stable(meanCur_r))
    else $error("Average current not refreshed on the tick.");

  AST_TTE_IDLE: assert property (@(posedge clk) disable iff (!rstn)
    (refreshTick && !discharging_flag) |=> (tte_r == 16'hFFFF) && (peakTte_r == 16'hFFFF))
    else $error("Time to empty not at sentinel while not discharging.");

  AST_TTF_IDLE: assert property (@(posedge clk) disable iff (!rstn)
    (refreshTick && !charging) |=> (ttf_r == 16'hFFFF))
    else $error("Time to full not at sentinel while not charging.");

  AST_POWER_ZERO: assert property (@(posedge clk) disable iff (!rstn)
    (refreshTick && !discharging_flag) |=> (power_r == 16'sh0000) && (cpTte_r == 16'hFFFF))
    else $error("Power not zero while not discharging.");

  AST_CP_TTE: assert property (@(posedge clk) disable iff (!rstn)
    (refreshTick && (avgPowerIn == 16'sh0000)) |=> (cpTte_r == 16'hFFFF))
    else $error("Constant-power time to empty not at sentinel for zero power.");

  AST_PEAK_FOLLOW: assert property (@(posedge clk) disable iff (!rstn)
    (primed_r && refreshTick && !(flags_r[9] && !fullPrev_r && belowHalf_r)
     && (gsr_abs(measCurrent) > gsr_abs(peak_r))) |=> (peak_r == $past(measCurrent)))
    else $error("Peak load current did not follow a larger current.");
endmodule : gsr_result_regs

// *** testbench/gauge_status_result_regs_tb_top.sv ***
// Self-checking bench of the gauge status and result bank.
`timescale 1ns/1ps
module gauge_status_result_regs_tb_top
  import gsr_pkg::*;
;
  typedef struct {logic [9:0] b; gsr_word_type t; gsr_word_type e;} gsr_row_type;
  logic          clk, rstn, hsel, hwrite, hready, hreadyout, hresp, refreshTick;
  logic [31:0]   haddr, hwdata, hrdata, d;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  logic [7:0]    stateOfCharge, full_flag_set_threshold;
  gsr_word_type  temperature, inhibitTempLow, inhibitTempHigh, suspendTempLow, suspendTempHigh;
  gsr_word_type  uncompRemaining, uncompFull, compRemaining, compFull, fullTimeIn, energyIn, idleDeadband;
  gsr_sword_type avgCurrentIn, measCurrent, avgPowerIn, initIdleCurrent, initPeakLoad;
  logic          overTempDetected, charging, discharging_flag, termination_met, fast_charge_allowed;
  logic          rest_voltage_good_flag, awaiting_pack_identify, pack_present_flag;
  logic          charge_level_threshold_one, system_shutdown_flag;
  logic [7:0]    ia[$];
  gsr_word_type  ea[$];
  int            errors, checks, cyc;
  gsr_row_type   rows[10] = '{
    '{10'h000, 16'h0096, 16'h0040}, '{10'h300, 16'h0096, 16'h8040}, '{10'h280, 16'h0096, 16'h4041},
    '{10'h000, 16'h00DC, 16'h0840}, '{10'h000, 16'h0028, 16'h0C40}, '{10'h040, 16'h0096, 16'h0240},
    '{10'h020, 16'h0096, 16'h0140}, '{10'h01F, 16'h0096, 16'h007E}, '{10'h200, 16'h0096, 16'h0040},
    '{10'h100, 16'h0096, 16'h0040}};

  assign hready = hreadyout;
  gsr_result_regs #(.TICK_CYCLES(20)) i_dut (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .temperature(temperature), .inhibitTempLow(inhibitTempLow), .inhibitTempHigh(inhibitTempHigh),
    .suspendTempLow(suspendTempLow), .suspendTempHigh(suspendTempHigh), .overTempDetected(overTempDetected),
    .charging(charging), .discharging_flag(discharging_flag), .termination_met(termination_met),
    .stateOfCharge(stateOfCharge), .full_flag_set_threshold(full_flag_set_threshold),
    .fast_charge_allowed(fast_charge_allowed), .rest_voltage_good_flag(rest_voltage_good_flag),
    .awaiting_pack_identify(awaiting_pack_identify), .pack_present_flag(pack_present_flag),
    .charge_level_threshold_one(charge_level_threshold_one), .system_shutdown_flag(system_shutdown_flag),
    .uncompRemaining(uncompRemaining), .uncompFull(uncompFull), .compRemaining(compRemaining),
    .compFull(compFull), .avgCurrentIn(avgCurrentIn), .measCurrent(measCurrent), .fullTimeIn(fullTimeIn),
    .energyIn(energyIn), .avgPowerIn(avgPowerIn), .initIdleCurrent(initIdleCurrent),
    .idleDeadband(idleDeadband), .initPeakLoad(initPeakLoad), .refreshTick(refreshTick));
  gsr_host_model i_host (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .hready(hready));

  always #5 clk = ~clk;

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      errors++;
      $display("[ERR] %0t run hung", $time);
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] idx, input gsr_word_type exp);
    i_host.xfer(idx, 1'h0, 32'h0, d);
    checks++;
    if (d !== {16'h0, exp} || hresp !== 1'h0)
    begin
      errors++;
      $display("[ERR] %0t word %h got %h want %h", $time, idx, d, exp);
    end
  endtask : chk

  task automatic apply(input gsr_row_type r);
    {overTempDetected, charging, discharging_flag, termination_met, fast_charge_allowed} <= r.b[9:5];
    {rest_voltage_good_flag, awaiting_pack_identify, pack_present_flag} <= r.b[4:2];
    {charge_level_threshold_one, system_shutdown_flag} <= r.b[1:0];
    temperature <= r.t;
    @(posedge clk);
    @(posedge clk);
  endtask : apply

  // Waits until a refresh pulse has been consumed by the bank.
  task automatic wait_tick();
    do @(negedge clk); while (refreshTick !== 1'h1);
    @(posedge clk);
    @(posedge clk);
  endtask : wait_tick

  task automatic chk_list();
    foreach (ia[i]) chk(ia[i], ea[i]);
  endtask : chk_list

  initial
  begin
    clk = 1'h0;
    rstn = 1'h0;
    {temperature, inhibitTempLow, inhibitTempHigh} = {16'h0096, 16'h0064, 16'h00C8};
    {suspendTempLow, suspendTempHigh, idleDeadband} = {16'h0032, 16'h00FA, 16'h000A};
    {uncompRemaining, uncompFull, compRemaining, compFull, fullTimeIn, energyIn} = '0;
    {avgCurrentIn, measCurrent, avgPowerIn} = '0;
    {initIdleCurrent, initPeakLoad} = {16'h0064, 16'h01F4};
    {stateOfCharge, full_flag_set_threshold} = '0;
    {overTempDetected, charging, discharging_flag, termination_met, fast_charge_allowed} = '0;
    {rest_voltage_good_flag, awaiting_pack_identify, pack_present_flag} = '0;
    {charge_level_threshold_one, system_shutdown_flag} = '0;
    repeat (20) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    chk(8'h0A, 16'h0040);
    chk(8'h1A, 16'h0064);
    chk(8'h1E, 16'h01F4);
    $display("reset values done");
    foreach (rows[i])
    begin
      apply(rows[i]);
      chk(8'h0A, rows[i].e);
    end
    $display("flag rows done");
    {uncompRemaining, uncompFull, compRemaining, compFull} <= {16'h01F4, 16'h0BB8, 16'h0258, 16'h0AF0};
    {avgCurrentIn, energyIn, avgPowerIn, measCurrent} <= {16'hFF88, 16'h03E8, 16'hFF38, 16'h0320};
    {charging, discharging_flag, stateOfCharge} <= {1'h0, 1'h1, 8'h28};
    wait_tick();
    wait_tick();
    ia = '{8'h0A, 8'h0C, 8'h0E, 8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h20, 8'h22, 8'h24, 8'h26};
    ea = '{16'h0041, 16'h01F4, 16'h0BB8, 16'h0258, 16'h0AF0, 16'hFF88, 16'h012C, 16'hFFFF,
           16'h0064, 16'h012C, 16'h0320, 16'h002D, 16'h03E8, 16'hFF38, 16'h012C};
    chk_list();
    $display("discharge results done");
    {discharging_flag, charging, termination_met, measCurrent, fullTimeIn} <= {3'h3, 16'h0000, 16'h0050};
    wait_tick();
    ia = '{8'h0A, 8'h16, 8'h18, 8'h1C, 8'h1E, 8'h20, 8'h24, 8'h26};
    ea = '{16'h0240, 16'hFFFF, 16'h0050, 16'hFFFF, 16'h028A, 16'hFFFF, 16'h0000, 16'hFFFF};
    chk_list();
    $display("charge results done");
    measCurrent <= 16'h0096;
    wait_tick();
    wait_tick();
    chk(8'h1A, 16'h0064);
    wait_tick();
    chk(8'h1A, 16'h0067);
    $display("idle filter done");
    {charging, termination_met, stateOfCharge, full_flag_set_threshold} <= {2'h0, 8'h46, 8'h3C};
    i_host.xfer(8'h0A, 1'h1, 32'h0000FFFF, d);
    i_host.xfer(8'h40, 1'h1, 32'h00000001, d);
    chk(8'h40, 16'h0001);
    chk(8'h0A, 16'h0240);
    stateOfCharge <= 8'h3B;
    @(posedge clk);
    @(posedge clk);
    chk(8'h0A, 16'h0040);
    chk(8'h30, 16'h0000);
    $display("control and unmapped done");
    rstn <= 1'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    chk(8'h1E, 16'h01F4);
    chk(8'h40, 16'h0000);
    $display("second reset done");
    finish_test();
  end
endmodule : gauge_status_result_regs_tb_top

// *** testbench/gsr_host_model.sv ***
// Host model that reads and writes gauge words over AHB-Lite.
`timescale 1ns/1ps
module gsr_host_model
  import gsr_pkg::*;
(
  // Clock.
  input  wire logic        clk,
  // AHB-Lite master side.
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata,
  input  wire logic [31:0] hrdata,
  input  wire logic        hready
);
  initial
  begin
    hsel   = 1'h0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // One whole-word transfer, entered just after a rising edge.
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'h1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    haddr  <= ~haddr;
    hwdata <= wr ? wd : ~hwdata;
    do @(posedge clk); while (hready !== 1'h1);
    rd = hrdata;
    hwdata <= ~hwdata;
  endtask : xfer
endmodule : gsr_host_model
